// *** shared/dio_pkg.sv ***
// Shared constants, types and helpers for the isolated dual-bank digital I/O block.
package dio_pkg;

    // Bank geometry and host word width.
    localparam int LINES_PER_BANK = 8;
    localparam int LINE_IDX_W = 3;
    localparam int WORD_W = 16;
    localparam int BANK_COUNT = 2;

    // Bank indices: the dedicated output bank and the dedicated input bank.
    localparam logic OUT_BANK = 1'b0;
    localparam logic IN_BANK = 1'b1;

    // Direction encoding, one bit per bank.
    localparam logic DIR_INPUT = 1'b0;
    localparam logic DIR_OUTPUT = 1'b1;

    // Field positions inside the command data word.
    localparam int LEVEL_BIT = 0;

    // Reset values.
    localparam logic [LINES_PER_BANK-1:0] OUT_LATCH_RST = 8'h00;
    localparam logic [BANK_COUNT-1:0] DIR_RST = 2'h0;
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

    // Host operations.
    typedef enum logic [2:0] {
        OP_WHOLE_BANK_READ = 3'h0,
        OP_SINGLE_LINE_READ = 3'h1,
        OP_WHOLE_BANK_WRITE = 3'h2,
        OP_SINGLE_LINE_WRITE = 3'h3,
        OP_DIRECTION_SETUP_CALL = 3'h4
    } op_e;

    // Completion status returned with every answer.
    typedef enum logic [2:0] {
        STATUS_OK = 3'h0,
        STATUS_WARN_OUTPUT_READ = 3'h1,
        STATUS_ERR_NOT_OUTPUT = 3'h2,
        STATUS_ERR_FIXED_DIR = 3'h3,
        STATUS_ERR_BAD_OP = 3'h4
    } status_e;

    // Sequencer states, Gray coded along idle, execute, reply.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_REPLY = 2'b11
    } state_e;

    // One host request.
    typedef struct packed {
        op_e op;
        logic bank;
        logic [LINE_IDX_W-1:0] line;
        logic [WORD_W-1:0] data;
    } cmd_s;

    // One answer to the host.
    typedef struct packed {
        logic [WORD_W-1:0] data;
        status_e status;
    } rsp_s;

    // Level of one line of a bank.
    function automatic logic line_pick(input logic [LINES_PER_BANK-1:0] v, input logic [LINE_IDX_W-1:0] idx);
        return v[idx];
    endfunction : line_pick

    // Bank value with one line replaced and all other lines kept.
    function automatic logic [LINES_PER_BANK-1:0] line_set(input logic [LINES_PER_BANK-1:0] v,
                                                           input logic [LINE_IDX_W-1:0] idx,
                                                           input logic level);
        logic [LINES_PER_BANK-1:0] r;
        r = v;
        r[idx] = level;
        return r;
    endfunction : line_set

    // Bank value placed in a host word with the upper bits forced low.
    function automatic logic [WORD_W-1:0] zero_extend(input logic [LINES_PER_BANK-1:0] v);
        return {{(WORD_W - LINES_PER_BANK){1'b0}}, v};
    endfunction : zero_extend

endpackage : dio_pkg

// *** verilog/dio_input_sync.sv ***
// Two-stage synchroniser for the isolated field input lines.
`timescale 1ns/10ps
`default_nettype none
module dio_input_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Asynchronous lines in, synchronised lines out.
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1;

    // The first stage feeds only the second; nothing else may look at it.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= '0;
            syncOut <= '0;
        end else begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end

endmodule : dio_input_sync
`default_nettype wire

// *** verilog/dio_change_detect.sv ***
// Registered change detector that pulses when any bit of a bus changes.
`timescale 1ns/10ps
`default_nettype none
module dio_change_detect #(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Watched bus and change pulse.
    input wire logic [WIDTH-1:0] watched,
    output logic changed
);

    logic [WIDTH-1:0] prevValue;
    logic primed;

    // The first cycle after reset only loads the history, so a bus that
    // comes up high does not report a change that never happened.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prevValue <= '0;
            primed <= 1'b0;
            changed <= 1'b0;
        end else begin
            prevValue <= watched;
            primed <= 1'b1;
            changed <= primed && (watched != prevValue);
        end
    end

endmodule : dio_change_detect
`default_nettype wire

// *** verilog/isolated_dual_port_dio.sv ***
// Top level of the isolated dual-bank digital I/O block with its host command sequencer.
`timescale 1ns/10ps
`default_nettype none
module isolated_dual_port_dio (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Host command channel.
    input wire logic cmdValid,
    output logic cmdReady,
    input wire dio_pkg::cmd_s cmd,
    // Host answer channel.
    output logic rspValid,
    input wire logic rspReady,
    output dio_pkg::rsp_s rsp,
    // Isolated field lines.
    input wire logic [dio_pkg::LINES_PER_BANK-1:0] inLinesPin,
    output logic [dio_pkg::LINES_PER_BANK-1:0] outLinesPin,
    // Block status.
    output logic [dio_pkg::BANK_COUNT-1:0] bankIsOutput,
    output logic inputChanged,
    output logic outputChanged
);

    // Sequencer and held request.
    dio_pkg::state_e state;
    dio_pkg::state_e next_state;
    dio_pkg::cmd_s held;

    // Output latch, bank directions and the registered answer.
    logic [dio_pkg::LINES_PER_BANK-1:0] outLatch;
    logic [dio_pkg::LINES_PER_BANK-1:0] next_outLatch;
    logic [dio_pkg::BANK_COUNT-1:0] dirOut;
    logic [dio_pkg::BANK_COUNT-1:0] next_dirOut;
    dio_pkg::rsp_s rspReg;
    dio_pkg::rsp_s next_rsp;

    // Synchronised field inputs.
    logic [dio_pkg::LINES_PER_BANK-1:0] inSample;

    // Field inputs cross into the clock domain through two flip-flops.
    dio_input_sync #(
        .WIDTH(dio_pkg::LINES_PER_BANK)
    ) u_input_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .asyncIn(inLinesPin),
        .syncOut(inSample)
    );

    // Change events on the synchronised inputs and on the driven outputs.
    dio_change_detect #(
        .WIDTH(dio_pkg::LINES_PER_BANK)
    ) u_input_change (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .watched(inSample),
        .changed(inputChanged)
    );

    dio_change_detect #(
        .WIDTH(dio_pkg::LINES_PER_BANK)
    ) u_output_change (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .watched(outLatch),
        .changed(outputChanged)
    );

    // Handshake decode.
    wire logic inIdle = (state == dio_pkg::ST_IDLE);
    wire logic inExec = (state == dio_pkg::ST_EXEC);
    wire logic inReply = (state == dio_pkg::ST_REPLY);
    wire logic take = cmdValid && inIdle;

    // Operation decode of the held request.
    wire logic opBankRead = (held.op == dio_pkg::OP_WHOLE_BANK_READ);
    wire logic opLineRead = (held.op == dio_pkg::OP_SINGLE_LINE_READ);
    wire logic opBankWrite = (held.op == dio_pkg::OP_WHOLE_BANK_WRITE);
    wire logic opLineWrite = (held.op == dio_pkg::OP_SINGLE_LINE_WRITE);
    wire logic opDirSetup = (held.op == dio_pkg::OP_DIRECTION_SETUP_CALL);
    wire logic opRead = opBankRead || opLineRead;
    wire logic opWrite = opBankWrite || opLineWrite;
    wire logic opKnown = opRead || opWrite || opDirSetup;

    // Bank selection: index 0 is the output bank, index 1 the input bank.
    wire logic selOut = (held.bank == dio_pkg::OUT_BANK);
    wire logic [dio_pkg::LINES_PER_BANK-1:0] bankValue = selOut ? outLatch : inSample;
    wire logic selIsOutput = (dirOut[held.bank] == dio_pkg::DIR_OUTPUT);

    // Line selection; a three-bit index covers exactly the eight lines.
    wire logic lineValue = dio_pkg::line_pick(bankValue, held.line);
    wire logic wantLevel = held.data[dio_pkg::LEVEL_BIT];

    // Read answer: a single line sits in bit zero, a bank in the low byte.
    wire logic [dio_pkg::WORD_W-1:0] lineWord = dio_pkg::zero_extend({7'h00, lineValue});
    wire logic [dio_pkg::WORD_W-1:0] bankWord = dio_pkg::zero_extend(bankValue);
    wire logic [dio_pkg::WORD_W-1:0] readWord = opLineRead ? lineWord : bankWord;

    // Write candidates: only the low byte of a bank write counts, and a line
    // write rebuilds the bank from the latch so other lines keep their level.
    wire logic [dio_pkg::LINES_PER_BANK-1:0] bankWriteValue = held.data[dio_pkg::LINES_PER_BANK-1:0];
    wire logic [dio_pkg::LINES_PER_BANK-1:0] lineWriteValue =
        dio_pkg::line_set(outLatch, held.line, wantLevel);
    wire logic [dio_pkg::LINES_PER_BANK-1:0] writeValue = opBankWrite ? bankWriteValue : lineWriteValue;

    // A write lands only on the output bank once it is set as output.
    wire logic writeAllowed = selOut && selIsOutput;
    wire logic doWrite = inExec && opWrite && writeAllowed;

    // The input bank has no drivers, so it may only ever be set as input.
    wire logic dirAllowed = selOut || (wantLevel == dio_pkg::DIR_INPUT);
    wire logic doDir = inExec && opDirSetup && dirAllowed;
    wire logic [dio_pkg::BANK_COUNT-1:0] dirUpdated =
        selOut ? {dirOut[dio_pkg::IN_BANK], wantLevel} : {wantLevel, dirOut[dio_pkg::OUT_BANK]};

    // Reading a bank that is set as output raises a warning, not an error.
    wire logic readWarn = opRead && selIsOutput;

    // Error for a refused write: input bank is fixed, output bank not yet enabled.
    wire dio_pkg::status_e writeStatus =
        writeAllowed ? dio_pkg::STATUS_OK :
        selOut ? dio_pkg::STATUS_ERR_NOT_OUTPUT : dio_pkg::STATUS_ERR_FIXED_DIR;

    wire dio_pkg::status_e dirStatus = dirAllowed ? dio_pkg::STATUS_OK : dio_pkg::STATUS_ERR_FIXED_DIR;

    wire dio_pkg::status_e readStatus =
        readWarn ? dio_pkg::STATUS_WARN_OUTPUT_READ : dio_pkg::STATUS_OK;

    // Final status; an unknown operation changes nothing.
    wire dio_pkg::status_e execStatus =
        !opKnown ? dio_pkg::STATUS_ERR_BAD_OP :
        opWrite ? writeStatus :
        opDirSetup ? dirStatus : readStatus;

    // Answer data: reads give the bank or line, writes echo the resulting
    // latch so the host sees what is driven, other operations give zero.
    wire logic [dio_pkg::WORD_W-1:0] execData =
        opRead ? readWord :
        opWrite ? dio_pkg::zero_extend(next_outLatch) : dio_pkg::WORD_ZERO;

    // Next values of the stored state.
    assign next_outLatch = doWrite ? writeValue : outLatch;
    assign next_dirOut = doDir ? dirUpdated : dirOut;
    assign next_rsp = inExec ? '{data: execData, status: execStatus} : rspReg;

    // Sequencer: take a request in idle, execute one cycle, hold the answer
    // until the host takes it. Holding the answer is what keeps a slow host
    // from losing a status, at the price of one request in flight.
    always_comb begin
        next_state = state;
        unique case (state)
            dio_pkg::ST_IDLE: begin
                if (take) begin
                    next_state = dio_pkg::ST_EXEC;
                end
            end
            dio_pkg::ST_EXEC: begin
                next_state = dio_pkg::ST_REPLY;
            end
            dio_pkg::ST_REPLY: begin
                if (rspReady) begin
                    next_state = dio_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = dio_pkg::ST_IDLE;
            end
        endcase
    end

    // Sequencer state and the request copy.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= dio_pkg::ST_IDLE;
            held <= '0;
        end else begin
            state <= next_state;
            if (take) begin
                held <= cmd;
            end
        end
    end

    // Output latch and directions; both banks start as input with lines low.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            outLatch <= dio_pkg::OUT_LATCH_RST;
            dirOut <= dio_pkg::DIR_RST;
        end else begin
            outLatch <= next_outLatch;
            dirOut <= next_dirOut;
        end
    end

    // Registered answer.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rspReg <= '{data: dio_pkg::WORD_ZERO, status: dio_pkg::STATUS_OK};
        end else begin
            rspReg <= next_rsp;
        end
    end

    // Port drive. The output lines follow the latch even while the bank is
    // set as input; the latch only moves after the bank has been enabled.
    assign cmdReady = inIdle;
    assign rspValid = inReply;
    assign rsp = rspReg;
    assign outLinesPin = outLatch;
    assign bankIsOutput = dirOut;

endmodule : isolated_dual_port_dio
`default_nettype wire

// *** sim/field_model.sv ***
// Behavioural field equipment that drives the isolated input lines of the block.
`timescale 1ns/10ps
`default_nettype none
module field_model (
    // Clock.
    input wire logic sys_clk,
    // Pattern requested by the bench and its strobe.
    input wire logic [7:0] levels,
    input wire logic load,
    // Lines into the block.
    output logic [7:0] inLinesPin
);
    // The lines move a little after the edge, so they reach the block out of step with its sampling.
    initial inLinesPin = 8'h00;
    always @(posedge sys_clk) begin
        if (load) begin
            inLinesPin <= #1 levels;
        end
    end
endmodule : field_model
`default_nettype wire

// *** sim/isolated_dual_port_dio_checker.sv ***
// Concurrent checks on the ports of the dual-bank digital I/O block.
`timescale 1ns/10ps
`default_nettype none
module isolated_dual_port_dio_checker (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Host channels.
    input wire logic cmdValid,
    input wire logic cmdReady,
    input wire dio_pkg::cmd_s cmd,
    input wire logic rspValid,
    input wire logic rspReady,
    input wire dio_pkg::rsp_s rsp,
    // Field lines and status.
    input wire logic [7:0] inLinesPin,
    input wire logic [7:0] outLinesPin,
    input wire logic [1:0] bankIsOutput,
    input wire logic inputChanged,
    input wire logic outputChanged
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // A request is taken, then one busy cycle passes before the answer shows.
    sequence take_s; cmdValid && cmdReady; endsequence
    sequence reply_s; !cmdReady ##1 rspValid; endsequence
    // Decoded views of the request; $past needs plain signals, not selects.
    wire logic isWr = cmd.op == dio_pkg::OP_WHOLE_BANK_WRITE || cmd.op == dio_pkg::OP_SINGLE_LINE_WRITE;
    wire logic isRd = cmd.op == dio_pkg::OP_WHOLE_BANK_READ || cmd.op == dio_pkg::OP_SINGLE_LINE_READ;
    wire logic [7:0] cmdByte = cmd.data[7:0];
    wire logic [7:0] lineMask = 8'h01 << cmd.line;
    wire logic cmdLevel = cmd.data[0];
    wire logic outEn = bankIsOutput[0] && cmd.bank == dio_pkg::OUT_BANK;
    answer_timing_a: assert property (take_s |=> reply_s) else $error("answer not two cycles after take");
    upper_zero_a: assert property (rspValid |-> rsp.data[15:8] == 8'h00) else $error("upper byte not zero");
    answer_hold_a: assert property (rspValid && !rspReady |=> rspValid && $stable(rsp))
        else $error("answer moved while waiting");
    fixed_bank_a: assert property (take_s ##0 (isWr && cmd.bank == dio_pkg::IN_BANK)
        |=> $stable(outLinesPin) ##1 ($stable(outLinesPin) && rsp.status == dio_pkg::STATUS_ERR_FIXED_DIR))
        else $error("input bank written");
    not_output_a: assert property (take_s ##0 (isWr && cmd.bank == dio_pkg::OUT_BANK && !bankIsOutput[0])
        |-> ##2 (rsp.status == dio_pkg::STATUS_ERR_NOT_OUTPUT && outLinesPin == $past(outLinesPin, 2)))
        else $error("write to disabled bank accepted");
    bank_write_a: assert property (take_s ##0 (cmd.op == dio_pkg::OP_WHOLE_BANK_WRITE && outEn)
        |-> ##2 outLinesPin == $past(cmdByte, 2)) else $error("bank write wrong lines");
    line_write_a: assert property (take_s ##0 (cmd.op == dio_pkg::OP_SINGLE_LINE_WRITE && outEn)
        |-> ##2 (((outLinesPin ^ $past(outLinesPin, 2)) & ~$past(lineMask, 2)) == 8'h00
        && (|(outLinesPin & $past(lineMask, 2))) == $past(cmdLevel, 2))) else $error("line write wrong");
    output_read_a: assert property (take_s ##0 (isRd && outEn)
        |-> ##2 rsp.status == dio_pkg::STATUS_WARN_OUTPUT_READ) else $error("no warning on output read");
    input_sample_a: assert property ($changed(inLinesPin) |-> ##3 inputChanged)
        else $error("input change missed");
    output_change_a: assert property ($changed(outLinesPin) |=> outputChanged)
        else $error("output change missed");
endmodule : isolated_dual_port_dio_checker
bind isolated_dual_port_dio isolated_dual_port_dio_checker chk (.sys_clk, .rst_b, .cmdValid, .cmdReady, .cmd, .rspValid,
    .rspReady, .rsp, .inLinesPin, .outLinesPin, .bankIsOutput, .inputChanged, .outputChanged);
`default_nettype wire

// *** sim/isolated_dual_port_dio_test.sv ***
// Self-checking testbench for the dual-bank digital I/O block.
`timescale 1ns/10ps
`default_nettype none
module isolated_dual_port_dio_test;
    // Short aliases for the host operations.
    localparam dio_pkg::op_e BR = dio_pkg::OP_WHOLE_BANK_READ;
    localparam dio_pkg::op_e LR = dio_pkg::OP_SINGLE_LINE_READ;
    localparam dio_pkg::op_e WB = dio_pkg::OP_WHOLE_BANK_WRITE;
    localparam dio_pkg::op_e LW = dio_pkg::OP_SINGLE_LINE_WRITE;
    localparam dio_pkg::op_e DS = dio_pkg::OP_DIRECTION_SETUP_CALL;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmdValid = 1'b0;
    logic rspReady = 1'b1;
    logic load = 1'b0;
    logic [7:0] levels = 8'h00;
    dio_pkg::cmd_s cmd = '0;
    dio_pkg::rsp_s rsp;
    logic cmdReady, rspValid, inputChanged, outputChanged;
    logic [7:0] inLinesPin, outLinesPin;
    logic [1:0] bankIsOutput;
    // Bench copy of the output latch and bank 0 direction.
    logic [7:0] latch = 8'h00;
    logic dirOut = 1'b0;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    always #2.5 sys_clk = ~sys_clk;
    isolated_dual_port_dio uut (.sys_clk, .rst_b, .cmdValid, .cmdReady, .cmd, .rspValid, .rspReady, .rsp,
        .inLinesPin, .outLinesPin, .bankIsOutput, .inputChanged, .outputChanged);
    field_model fm (.sys_clk, .levels, .load, .inLinesPin);
    // The host stalls answers at random so back-pressure is exercised throughout.
    always @(posedge sys_clk) begin
        rspReady <= $urandom_range(0, 3) != 0;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end
    // Expected answer from the bench state; writes report the latch after the update.
    function automatic dio_pkg::rsp_s predict(input dio_pkg::cmd_s c);
        dio_pkg::rsp_s r;
        logic [7:0] v;
        v = c.bank ? inLinesPin : latch;
        r.status = (!c.bank && dirOut) ? dio_pkg::STATUS_WARN_OUTPUT_READ : dio_pkg::STATUS_OK;
        r.data = (c.op == LR) ? {15'h0000, v[c.line]} : {8'h00, v};
        if (c.op == WB || c.op == LW) begin
            r.status = c.bank ? dio_pkg::STATUS_ERR_FIXED_DIR : (dirOut ? dio_pkg::STATUS_OK : dio_pkg::STATUS_ERR_NOT_OUTPUT);
            r.data = (r.status == dio_pkg::STATUS_OK && c.op == WB) ? {8'h00, c.data[7:0]} : {8'h00, latch};
            if (r.status == dio_pkg::STATUS_OK && c.op == LW) begin
                r.data[c.line] = c.data[0];
            end
        end
        if (c.op == DS) begin
            r.data = 16'h0000;
            r.status = (c.bank && c.data[0]) ? dio_pkg::STATUS_ERR_FIXED_DIR : dio_pkg::STATUS_OK;
        end
        if (c.op > DS) begin
            r.data = 16'h0000;
            r.status = dio_pkg::STATUS_ERR_BAD_OP;
        end
        return r;
    endfunction : predict
    task automatic check(input string what, input logic [18:0] exp, input logic [18:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // One whole request and answer; the request stands until taken, the answer is read where accepted.
    task automatic xfer(input dio_pkg::op_e op, input logic bank, input logic [2:0] line, input logic [15:0] data);
        dio_pkg::cmd_s c;
        dio_pkg::rsp_s want;
        int n;
        c = '{op, bank, line, data};
        want = predict(c);
        if ((op == WB || op == LW) && want.status == dio_pkg::STATUS_OK) begin
            latch = want.data[7:0];
        end
        if (op == DS && !bank) begin
            dirOut = data[0];
        end
        @(posedge sys_clk);
        cmdValid <= 1'b1;
        cmd <= c;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (cmdReady !== 1'b1 && n < 50);
        @(posedge sys_clk);
        cmdValid <= 1'b0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (!(rspValid === 1'b1 && rspReady === 1'b1) && n < 60);
        if (rspValid !== 1'b1 || rspReady !== 1'b1) begin
            num_errors++;
            $display("mismatch answer handshake expected 1 seen 0");
        end
        check("answer", want, rsp);
        check("lines", {11'h000, latch}, {11'h000, outLinesPin});
        @(posedge sys_clk);
    endtask : xfer
    task automatic drive_pins(input logic [7:0] v);
        @(posedge sys_clk);
        levels <= v;
        load <= 1'b1;
        @(posedge sys_clk);
        load <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask : drive_pins
    task automatic do_reset();
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        latch = 8'h00;
        dirOut = 1'b0;
        @(negedge sys_clk);
        check("direction", 19'h00000, {17'h00000, bankIsOutput});
        check("reset lines", 19'h00000, {11'h000, outLinesPin});
    endtask : do_reset
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    // Corner cases first, then random traffic, then a reset in mid-run with the lines set.
    initial begin
        dio_pkg::op_e op;
        void'($urandom(32'hc4d00644));
        do_reset();
        xfer(WB, 1'b0, 3'h0, 16'h00ff);
        xfer(DS, 1'b1, 3'h0, 16'h0001);
        xfer(DS, 1'b1, 3'h0, 16'h0000);
        xfer(DS, 1'b0, 3'h0, 16'h0001);
        xfer(WB, 1'b0, 3'h0, 16'ha55a);
        xfer(LW, 1'b0, 3'h7, 16'h0001);
        xfer(LW, 1'b0, 3'h1, 16'hfffe);
        xfer(WB, 1'b1, 3'h0, 16'h1234);
        xfer(BR, 1'b0, 3'h0, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            drive_pins(8'(1 << i));
            xfer(LR, 1'b1, i[2:0], 16'h0000);
            xfer(BR, 1'b1, 3'h0, 16'h0000);
        end
        for (int k = 5; k < 8; k++) begin
            xfer(dio_pkg::op_e'(k), 1'b0, 3'h0, 16'h00ff);
        end
        repeat (60) begin
            if ($urandom_range(0, 9) == 0) begin
                drive_pins(8'($urandom));
            end
            op = dio_pkg::op_e'($urandom_range(0, 4));
            xfer(op, (op == DS) ? 1'b0 : 1'($urandom), 3'($urandom), 16'($urandom));
        end
        xfer(DS, 1'b0, 3'h0, 16'h0001);
        xfer(WB, 1'b0, 3'h0, 16'h00c3);
        do_reset();
        xfer(WB, 1'b0, 3'h0, 16'h00ff);
        close_out();
    end
endmodule : isolated_dual_port_dio_test
`default_nettype wire
